// ===== hdl/regc_pkg.sv
/*
  Constants for the rail enable-gating configuration block: register
  offsets, field positions, reset values and delay counts.
  Assumes a 50 MHz clock and a byte-wide register port driven by logic
  on the same clock.
*/
// Notes on behaviour
// - first register holds eight power-good mask bits
// - mask 0 includes power-good, 1 ignores it
// - second register bits 1,0 mask two more rails
// - bits 4:2 pick the enable control pin
// - code 111 forces constant one enable source
// - third register bits 5:3 delay falling edge
// - bits 2:0 delay rising edge, same table
// - delays stay within ten percent of nominal
package regc_pkg;
  localparam logic [7:0] REGC_OFS_MASK_A = 8'h0a;
  localparam logic [7:0] REGC_OFS_SEL    = 8'h0b;
  localparam logic [7:0] REGC_OFS_DELAY  = 8'h0c;

  localparam logic [7:0] REGC_RST_MASK_A = 8'h00;
  localparam logic [7:0] REGC_RST_SEL    = 8'hc0;
  localparam logic [7:0] REGC_RST_DELAY  = 8'h00;

  localparam int REGC_SEL_LSB  = 2;
  localparam int REGC_STEP_BIT = 5;
  localparam int REGC_FALL_LSB = 3;
  localparam int REGC_RISE_LSB = 0;

  typedef enum logic [2:0] {
    REGC_SRC_PIN1  = 3'h0,
    REGC_SRC_PIN2  = 3'h1,
    REGC_SRC_PIN5  = 3'h2,
    REGC_SRC_PIN4  = 3'h3,
    REGC_SRC_PIN3  = 3'h4,
    REGC_SRC_PIN34 = 3'h5,
    REGC_SRC_PIN6  = 3'h6,
    REGC_SRC_ONE   = 3'h7
  } regc_src_t;

  localparam int REGC_CLK_HZ    = 50_000_000;
  localparam int REGC_TICK_US   = 1000;
  // one ms tick; exact, so all codes are nominal and inside tolerance
  localparam int REGC_TICK_CYC  = REGC_CLK_HZ / 1_000_000 * REGC_TICK_US;
  localparam int REGC_TICK_W    = 16;
  localparam int REGC_MS_W      = 7;
endpackage : regc_pkg

// ===== hdl/regc_rail_enable.sv
/*
  Enable gating for one regulator rail: three configuration registers,
  power-good masking, enable source selection and edge delays.
  Assumes pins and power-good flags are asynchronous; register port is
  synchronous to mclk_i.
*/
`timescale 1ns/1ps
module regc_rail_enable #(
  parameter int TICK_CYC = regc_pkg::REGC_TICK_CYC
) (
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] otp_mask_a_i,
  input  wire logic [7:0] otp_sel_i,
  input  wire logic [7:0] otp_delay_i,
  input  wire logic       otp_load_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_write_i,
  output logic [7:0]      reg_rdata_o,
  input  wire logic [5:0] control_pin_i,
  input  wire logic [9:0] power_good_i,
  output logic            controlled_rail_enable_o,
  output logic            voltage_step_size_o
);
  logic [7:0]  rail_power_good_mask_a;
  logic [7:0]  rail_enable_select_step;
  logic [7:0]  rail_enable_edge_delay;
  logic [15:0] pin_sync1;
  logic [15:0] pin_sync2;
  logic [15:0] tick_cnt;
  logic [6:0]  ms_cnt;
  logic        enable_q;
  logic [7:0]  rdata_q;
  // assertion helpers: cycles the request has held at its present level
  logic [22:0] rise_run;
  logic [22:0] fall_run;

  // synchronise pins and goods together: bits 15:10 pins, 9:0 goods
  always_ff @(posedge mclk_i) begin
    pin_sync1 <= {control_pin_i, power_good_i};
    pin_sync2 <= pin_sync1;
  end

  wire [5:0] pin_s  = pin_sync2[15:10];
  wire [9:0] good_s = pin_sync2[9:0];

  function automatic logic [6:0] regc_delay_ms(input logic [2:0] code);
    case (code)
      3'h0:    regc_delay_ms = 7'h00;
      3'h1:    regc_delay_ms = 7'h02;
      3'h2:    regc_delay_ms = 7'h04;
      3'h3:    regc_delay_ms = 7'h08;
      3'h4:    regc_delay_ms = 7'h10;
      3'h5:    regc_delay_ms = 7'h18;
      3'h6:    regc_delay_ms = 7'h20;
      default: regc_delay_ms = 7'h40;
    endcase
  endfunction

  // register port
  wire sel_mask = reg_addr_i == regc_pkg::REGC_OFS_MASK_A;
  wire sel_sel  = reg_addr_i == regc_pkg::REGC_OFS_SEL;
  wire sel_dly  = reg_addr_i == regc_pkg::REGC_OFS_DELAY;

  // reset loads the package reset values; the programmed store is loaded on request
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      rail_power_good_mask_a       <= regc_pkg::REGC_RST_MASK_A;
      rail_enable_select_step <= regc_pkg::REGC_RST_SEL;
      rail_enable_edge_delay  <= regc_pkg::REGC_RST_DELAY;
    end else if (otp_load_i) begin
      rail_power_good_mask_a       <= otp_mask_a_i;
      rail_enable_select_step <= otp_sel_i;
      rail_enable_edge_delay  <= otp_delay_i;
    end else if (reg_write_i) begin
      if (sel_mask) rail_power_good_mask_a <= reg_wdata_i;
      // step bit writable; programming flow is expected to own it
      if (sel_sel) rail_enable_select_step <= {rail_enable_select_step[7:6], reg_wdata_i[5:0]};
      if (sel_dly) rail_enable_edge_delay <= {rail_enable_edge_delay[7:6], reg_wdata_i[5:0]};
    end
  end

  wire [7:0] rdata_mux = sel_mask ? rail_power_good_mask_a :
                         sel_sel  ? rail_enable_select_step :
                         sel_dly  ? rail_enable_edge_delay : 8'h00;

  // read data from a flop: it stands one cycle after the address is set
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_mux;
    end
  end

  assign reg_rdata_o = rdata_q;

  assign voltage_step_size_o = rail_enable_select_step[regc_pkg::REGC_STEP_BIT];

  // power_good_i[7:0] follow mask_a bit order, [9:8] = switch_b2_ldo_a1, switch_b1
  wire [9:0] good_mask = {rail_enable_select_step[1:0], rail_power_good_mask_a};
  wire       goods_ok  = &(good_s | good_mask);

  regc_pkg::regc_src_t src;
  assign src = regc_pkg::regc_src_t'(rail_enable_select_step[regc_pkg::REGC_SEL_LSB +: 3]);
  logic src_on;
  always_comb begin
    case (src)
      regc_pkg::REGC_SRC_PIN1:  src_on = pin_s[0];
      regc_pkg::REGC_SRC_PIN2:  src_on = pin_s[1];
      regc_pkg::REGC_SRC_PIN5:  src_on = pin_s[4];
      regc_pkg::REGC_SRC_PIN4:  src_on = pin_s[3];
      regc_pkg::REGC_SRC_PIN3:  src_on = pin_s[2];
      regc_pkg::REGC_SRC_PIN34: src_on = pin_s[2] & pin_s[3];
      regc_pkg::REGC_SRC_PIN6:  src_on = pin_s[5];
      default:                  src_on = 1'b1;
    endcase
  end

  wire request = src_on & goods_ok;

  typedef enum logic [1:0] {REGC_OFF, REGC_RISING, REGC_ON, REGC_FALLING} regc_state_t;
  regc_state_t state;
  regc_state_t next_state;

  wire [6:0] rise_ms = regc_delay_ms(rail_enable_edge_delay[regc_pkg::REGC_RISE_LSB +: 3]);
  wire [6:0] fall_ms = regc_delay_ms(rail_enable_edge_delay[regc_pkg::REGC_FALL_LSB +: 3]);
  wire [6:0] tgt_ms  = (state == REGC_RISING) ? rise_ms : fall_ms;
  wire       tick    = tick_cnt == 16'(TICK_CYC - 1);
  wire       done    = (ms_cnt >= tgt_ms);

  always_comb begin
    case (state)
      REGC_OFF:     next_state = request ? REGC_RISING : REGC_OFF;
      REGC_RISING:  next_state = !request ? REGC_OFF : (done ? REGC_ON : REGC_RISING);
      REGC_ON:      next_state = request ? REGC_ON : REGC_FALLING;
      REGC_FALLING: next_state = request ? REGC_ON : (done ? REGC_OFF : REGC_FALLING);
      default:      next_state = REGC_OFF;
    endcase
  end

  // delay counted in exact 1 ms ticks from edge of request
  always_ff @(posedge mclk_i) begin
    if (!nrst_i || next_state != state) begin
      tick_cnt <= 16'h0000;
      ms_cnt   <= 7'h00;
    end else if (tick) begin
      tick_cnt <= 16'h0000;
      ms_cnt   <= ms_cnt + 7'h01;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      state    <= REGC_OFF;
      enable_q <= 1'b0;
    end else begin
      state    <= next_state;
      // flop follows the state being entered, so it adds no lag
      enable_q <= (next_state == REGC_ON) || (next_state == REGC_FALLING);
    end
  end

  assign controlled_rail_enable_o = enable_q;

  localparam logic [22:0] RUN_MAX = 23'h7fffff;

  // saturating, so a rail left on for hours cannot wrap the count
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      rise_run <= 23'h000000;
      fall_run <= 23'h000000;
    end else begin
      rise_run <= !request ? 23'h000000 : ((rise_run == RUN_MAX) ? rise_run : rise_run + 23'h000001);
      fall_run <= request ? 23'h000000 : ((fall_run == RUN_MAX) ? fall_run : fall_run + 23'h000001);
    end
  end

  // rail off and every unmasked good present: only the source decides
  sequence s_idle_goods;
    (state == REGC_OFF) && goods_ok;
  endsequence

  property p_code7_one;
    @(posedge mclk_i) disable iff (!nrst_i)
      s_idle_goods ##0 (src == regc_pkg::REGC_SRC_ONE) |=> (state == REGC_RISING);
  endproperty
  a_code7_one: assert property (p_code7_one) else $error("code 111 not forcing one");

  property p_mask_ignores;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state == REGC_OFF && src_on && (&good_mask)) |=> (state == REGC_RISING);
  endproperty
  a_mask_ignores: assert property (p_mask_ignores) else $error("masked goods still gate");

  property p_no_early_on;
    @(posedge mclk_i) disable iff (!nrst_i)
      $rose(controlled_rail_enable_o) |-> $past(request) && ($past(rise_run) > $past(rise_ms) * TICK_CYC);
  endproperty
  a_no_early_on: assert property (p_no_early_on) else $error("enable rose without request");

  property p_rsv_kept;
    @(posedge mclk_i) disable iff (!nrst_i) (reg_write_i && sel_sel && !otp_load_i) |=>
      rail_enable_select_step[7:6] == $past(rail_enable_select_step[7:6]);
  endproperty
  a_rsv_kept: assert property (p_rsv_kept) else $error("reserved bits changed");

  property p_pair34;
    @(posedge mclk_i) disable iff (!nrst_i)
      s_idle_goods ##0 (src == regc_pkg::REGC_SRC_PIN34) |=> (state == REGC_RISING) == $past(pin_s[2] & pin_s[3]);
  endproperty
  a_pair34: assert property (p_pair34) else $error("pin pair select wrong");

  property p_zero_rise;
    @(posedge mclk_i) disable iff (!nrst_i)
      (state == REGC_RISING && rise_ms == 7'h00 && request) |=> controlled_rail_enable_o;
  endproperty
  a_zero_rise: assert property (p_zero_rise) else $error("zero rise delay not immediate");

  property p_fall_hold;
    @(posedge mclk_i) disable iff (!nrst_i)
      $fell(controlled_rail_enable_o) |-> !$past(request) && ($past(fall_run) > $past(fall_ms) * TICK_CYC);
  endproperty
  a_fall_hold: assert property (p_fall_hold) else $error("enable dropped before fall delay");

  property p_step_out;
    @(posedge mclk_i) disable iff (!nrst_i) (reg_write_i && sel_sel && !otp_load_i) |=>
      voltage_step_size_o == $past(reg_wdata_i[5]);
  endproperty
  a_step_out: assert property (p_step_out) else $error("step size not updated");

endmodule : regc_rail_enable

// ===== sim/testbench.sv
/*
  Self-checking bench for regc_rail_enable: registers, source select, masks, edge delays.
  Assumes TICK_CYC shortened to 10 cycles per millisecond.
*/
`timescale 1ns/1ps
module testbench;
  logic       mclk_i = 1'b0, nrst_i = 1'b0, otp_load_i = 1'b0, reg_write_i = 1'b0;
  logic [7:0] otp_mask_a_i = 8'h00, otp_sel_i = 8'h00, otp_delay_i = 8'h00;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic [5:0] control_pin_i = 6'h00;
  logic [9:0] power_good_i = 10'h000;
  logic       en_o, step_o;
  logic [7:0] ma, sl, v;
  int bad_count = 0, check_count = 0, cyc = 0, seed = 13160, c, k, n, lo, hi;
  int ms_tab[8] = '{0, 2, 4, 8, 16, 24, 32, 64};

  regc_rail_enable #(.TICK_CYC(10)) uut (.mclk_i(mclk_i), .nrst_i(nrst_i), .otp_mask_a_i(otp_mask_a_i),
    .otp_sel_i(otp_sel_i), .otp_delay_i(otp_delay_i), .otp_load_i(otp_load_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_rdata_o(reg_rdata_o),
    .control_pin_i(control_pin_i), .power_good_i(power_good_i),
    .controlled_rail_enable_o(en_o), .voltage_step_size_o(step_o));

  initial forever #10 mclk_i = ~mclk_i;
  // ceiling well above the longest delay sweep
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i) reg_addr_i = a;
    reg_wdata_i = d;
    reg_write_i = 1'b1;
    @(negedge mclk_i) reg_write_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk_i) reg_addr_i = a;
    // read data is a flop: it stands from the next rising edge
    @(negedge mclk_i) check(reg_rdata_o, exp);
  endtask
  // reference request: selected source and every unmasked good
  function automatic logic req(input logic [7:0] s, input logic [7:0] m, input logic [5:0] p,
                               input logic [9:0] g);
    logic x;
    case (s[4:2])
      3'h0: x = p[0];
      3'h1: x = p[1];
      3'h2: x = p[4];
      3'h3: x = p[3];
      3'h4: x = p[2];
      3'h5: x = p[2] & p[3];
      3'h6: x = p[5];
      default: x = 1'b1;
    endcase
    return x & (&(g | {s[1], s[0], m}));
  endfunction
  task automatic meas(input logic lvl);
    n = 0;
    while (en_o !== lvl && n < 1000) begin
      @(negedge mclk_i) n++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(negedge mclk_i);
    nrst_i = 1'b1;
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'hc0);
    rd(8'h0c, 8'h00);
    rd(8'h0d, 8'h00);
    otp_mask_a_i = 8'($random(seed));
    otp_sel_i = {2'b11, 6'($random(seed))};
    otp_delay_i = {2'b00, 6'($random(seed))};
    @(negedge mclk_i) otp_load_i = 1'b1;
    @(negedge mclk_i) otp_load_i = 1'b0;
    rd(8'h0a, otp_mask_a_i);
    rd(8'h0b, otp_sel_i);
    rd(8'h0c, otp_delay_i);
    // reserved bits keep their value whatever is written
    for (k = 0; k < 4; k++) begin
      v = 8'($random(seed));
      // step size follows both the programmed load and register writes; both set it to v[5]
      otp_sel_i = {2'b11, v[5], ~v[4:0]};
      @(negedge mclk_i) otp_load_i = 1'b1;
      @(negedge mclk_i) otp_load_i = 1'b0;
      wr(8'h0a, v);
      wr(8'h0b, v);
      wr(8'h0c, v);
      wr(8'h0d, ~v);
      rd(8'h0a, v);
      rd(8'h0b, {2'b11, v[5:0]});
      rd(8'h0c, {2'b00, v[5:0]});
      check({7'h00, step_o}, {7'h00, v[5]});
    end
    wr(8'h0c, 8'h00);
    for (c = 0; c < 32; c++) begin
      ma = 8'($random(seed) | $random(seed));
      sl = {2'b11, v[5], 3'(c / 4), 2'($random(seed) | $random(seed))};
      wr(8'h0a, ma);
      wr(8'h0b, sl);
      control_pin_i = 6'($random(seed));
      power_good_i = 10'($random(seed) | $random(seed));
      repeat (12) @(negedge mclk_i);
      check({7'h00, en_o}, {7'h00, req(sl, ma, control_pin_i, power_good_i)});
    end
    // every good masked: dead supplies must not hold the rail off
    wr(8'h0a, 8'hff);
    wr(8'h0b, {2'b11, v[5], 5'h03});
    control_pin_i = 6'h01;
    power_good_i = 10'h000;
    repeat (12) @(negedge mclk_i);
    check({7'h00, en_o}, 8'h01);
    control_pin_i = 6'h00;
    wr(8'h0a, 8'h00);
    wr(8'h0b, {2'b11, v[5], 5'h00});
    power_good_i = 10'h3ff;
    for (c = 0; c < 8; c++) begin
      wr(8'h0c, {2'b00, 3'(c), 3'(c)});
      lo = ms_tab[c] * 10;
      hi = ms_tab[c] * 11 + 8;
      if (c > 0) begin
        // request lost mid-delay must abort the rise
        @(negedge mclk_i) control_pin_i = 6'h01;
        repeat (lo / 2) @(negedge mclk_i);
        control_pin_i = 6'h00;
        repeat (lo) @(negedge mclk_i);
        check({7'h00, en_o}, 8'h00);
      end
      @(negedge mclk_i) control_pin_i = 6'h01;
      meas(1'b1);
      check({7'h00, n >= lo && n <= hi}, 8'h01);
      @(negedge mclk_i) control_pin_i = 6'h00;
      meas(1'b0);
      check({7'h00, n >= lo && n <= hi}, 8'h01);
    end
    tally_and_finish();
  end
endmodule // testbench
